/* dma_ext_req.sv */
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module dma_ext_req
  import dma_ext_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_external_bus_clock,
  input wire logic [NCH-1:0] i_ext_transfer_request_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_bsc_req,
  output logic [1:0] o_bsc_chan,
  output logic o_bsc_write,
  output logic o_bsc_single,
  input wire logic i_bsc_done,
  output logic o_bus_hold,
  output logic [NCH-1:0] o_transfer_ack_strobe,
  output logic [NCH-1:0] o_request_accepted_pulse
);
  logic ck1_q;
  logic ck2_q;
  logic ck3_q;
  logic bclk_en;
  logic [CTL_W-1:0] ctl_q [NCH];
  logic [CNT_W-1:0] cnt_q [NCH];
  logic [1:0] glb_q;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] edg;
  logic [NCH-1:0] elig;
  logic [NCH-1:0] det;
  logic [NCH-1:0] resamp;
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] samp_en_q;
  logic [NCH-1:0] acc_q;
  logic [NCH-1:0] ack_q;
  logic [NCH-1:0] ack_d;
  logic [NCH-1:0] cur_oh;
  seq_t st_q;
  logic [1:0] cur_q;
  logic [1:0] last_q;
  logic [2:0] wait_q;
  logic [1:0] age_q;
  logic done_q;
  logic hold_q;
  logic bsc_req_q;
  logic [1:0] gnt;
  logic any_req;
  logic [CTL_W-1:0] cc;
  logic c_dual;
  logic c_burst;
  logic c_edge;
  logic c_last;
  logic unit_end;
  logic keep_bus;
  logic [2:0] lat_pick;
  logic [CTL_W-1:0] gc;
  logic apb_setup;
  logic apb_wr;
  logic [AW-1:0] reg_ofs;
  logic [1:0] reg_ch;
  logic hit_ctrl;
  logic hit_cnt;
  logic hit_glb;
  logic hit_stat;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // External bus clock: synchronise and find its rising edges
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ck1_q <= 1'b0;
      ck2_q <= 1'b0;
      ck3_q <= 1'b0;
    end else begin
      ck1_q <= i_external_bus_clock;
      ck2_q <= ck1_q;
      ck3_q <= ck2_q;
    end
  end
  assign bclk_en = ck2_q & ~ck3_q;

  // Request pin samplers, one per channel
  for (genvar g = 0; g < NCH; g++) begin : g_samp
    dma_req_sampler u_samp (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_bclk_en(bclk_en),
      .i_req_n(i_ext_transfer_request_n[g]),
      .o_level(lvl[g]),
      .o_edge(edg[g])
    );
    assign elig[g] = ctl_q[g][F_EN] && (cnt_q[g] != '0) &&
      ext_ok(2'(g), glb_q[G_HS], ctl_q[g][F_DUAL], ctl_q[g][F_MEM +: 3]);
    assign det[g] = bclk_en & samp_en_q[g] & elig[g] &
      (ctl_q[g][F_EDGE] ? edg[g] : lvl[g]);
    assign cur_oh[g] = (cur_q == 2'(g)) && (st_q != st_idle);
  end

  // Current channel decode
  assign cc = ctl_q[cur_q];
  assign c_dual = cc[F_DUAL];
  assign c_burst = cc[F_BURST];
  assign c_edge = cc[F_EDGE];
  assign c_last = (cnt_q[cur_q] == CNT_W'(1));
  assign unit_end = bclk_en & done_q &
    ((st_q == st_wr) | ((st_q == st_rd) & ~c_dual));

  // Resampling point for the running channel
  always_comb begin
    resamp = '0;
    if (bclk_en && st_q != st_idle) begin
      if (!c_edge) begin
        if (c_dual) begin
          resamp[cur_q] = (st_q == st_wr) && (age_q == 2'h0);
        end else begin
          resamp[cur_q] = (st_q == st_rd) && (age_q == 2'h0);
        end
      end else if (!c_burst && c_dual) begin
        resamp[cur_q] = (st_q == st_rd) && done_q;
      end
    end
  end

  // Bus is kept between units only for bursts: edge bursts still owed data, level bursts while another channel is pending
  assign keep_bus = c_burst &
    (c_edge ? ~c_last : |(pend_q & elig & ~cur_oh));

  // Per-channel sampling gate, pending request and accepted pulse
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      samp_en_q <= '1;
      pend_q <= '0;
      acc_q <= '0;
    end else begin
      for (int k = 0; k < NCH; k++) begin
        if (bclk_en) begin
          acc_q[k] <= det[k];
        end
        if (det[k]) begin
          samp_en_q[k] <= 1'b0;
        end else if (resamp[k] || !elig[k]) begin
          samp_en_q[k] <= 1'b1;
        end else if (bclk_en && acc_q[k] && ctl_q[k][F_EDGE] &&
                     !ctl_q[k][F_BURST] && !ctl_q[k][F_DUAL]) begin
          samp_en_q[k] <= 1'b1;
        end
        if (det[k]) begin
          pend_q[k] <= 1'b1;
        end else if (!elig[k]) begin
          pend_q[k] <= 1'b0;
        end else if (unit_end && cur_q == 2'(k) &&
                     !(c_burst && c_edge && !c_last)) begin
          pend_q[k] <= 1'b0;
        end
      end
    end
  end

  // Priority pick among pending channels
  dma_prio_arb u_arb (
    .i_req(pend_q & elig),
    .i_rr(glb_q[G_RR]),
    .i_last(last_q),
    .o_idx(gnt),
    .o_any(any_req)
  );

  // Earliest start depends on detection method and block size
  assign gc = ctl_q[gnt];
  assign lat_pick = gc[F_EDGE] ? LAT_EDGE :
    ((gc[F_BLK] & ~gc[F_DUAL]) ? LAT_BLK : LAT_LEVEL);

  // Transfer sequencer, stepped on bus clock edges
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= st_idle;
      cur_q <= 2'h0;
      last_q <= 2'h3;
      wait_q <= 3'h0;
      age_q <= 2'h0;
      hold_q <= 1'b0;
      bsc_req_q <= 1'b0;
    end else if (bclk_en) begin
      if (age_q != 2'h3) begin
        age_q <= 2'(age_q + 2'h1);
      end
      unique case (st_q)
        st_idle: begin
          if (any_req) begin
            cur_q <= gnt;
            age_q <= 2'h0;
            if (hold_q) begin
              st_q <= st_rd;
              bsc_req_q <= 1'b1;
            end else begin
              st_q <= st_wait;
              wait_q <= 3'(lat_pick - 3'h2);
              hold_q <= 1'b1;
            end
          end else begin
            hold_q <= 1'b0;
          end
        end
        st_wait: begin
          if (wait_q == 3'h0) begin
            st_q <= st_rd;
            age_q <= 2'h0;
            bsc_req_q <= 1'b1;
          end else begin
            wait_q <= 3'(wait_q - 3'h1);
          end
        end
        st_rd: begin
          if (done_q) begin
            age_q <= 2'h0;
            if (c_dual) begin
              st_q <= st_wr;
            end else begin
              st_q <= st_idle;
              bsc_req_q <= 1'b0;
              last_q <= cur_q;
              hold_q <= keep_bus;
            end
          end
        end
        st_wr: begin
          if (done_q) begin
            st_q <= st_idle;
            age_q <= 2'h0;
            bsc_req_q <= 1'b0;
            last_q <= cur_q;
            hold_q <= keep_bus;
          end
        end
      endcase
    end
  end

  // Bus state controller finished the cycle; held until the bus clock
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      done_q <= 1'b0;
    end else if (i_bsc_done && bsc_req_q) begin
      done_q <= 1'b1;
    end else if (bclk_en) begin
      done_q <= 1'b0;
    end
  end

  // Acknowledge strobe follows the bus cycle of the running channel
  always_comb begin
    ack_d = '0;
    if (st_q == st_rd || st_q == st_wr) begin
      ack_d[cur_q] = ~c_dual | ((st_q == st_wr) == cc[F_ACKWR]);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_q <= '0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // Register decode
  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr = i_psel & i_penable & i_pwrite & pready_q & ~pslverr_q;
  assign reg_ofs = {i_paddr[AW-1:4], 4'h0};
  assign reg_ch = i_paddr[3:2];
  assign hit_ctrl = (reg_ofs == OFS_CTRL) && (i_paddr[1:0] == 2'h0);
  assign hit_cnt = (reg_ofs == OFS_CNT) && (i_paddr[1:0] == 2'h0);
  assign hit_glb = (i_paddr == OFS_GLB);
  assign hit_stat = (i_paddr == OFS_STAT);
  assign rd_mux = hit_ctrl ? 32'(ctl_q[reg_ch]) :
    hit_cnt ? 32'(cnt_q[reg_ch]) :
    hit_glb ? 32'(glb_q) :
    hit_stat ? {16'h0, 2'(st_q), cur_q, 1'b0, hold_q, 2'h0, pend_q, samp_en_q} :
    32'h0;

  // Bus answer one cycle after setup, unmapped offsets flag an error
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~(hit_ctrl | hit_cnt | hit_glb | hit_stat);
      if (apb_setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Control registers; a finished unit counts down
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      glb_q <= 2'h0;
      for (int k = 0; k < NCH; k++) begin
        ctl_q[k] <= '0;
        cnt_q[k] <= '0;
      end
    end else begin
      if (apb_wr && hit_glb) begin
        glb_q <= i_pwdata[1:0];
      end
      for (int k = 0; k < NCH; k++) begin
        if (apb_wr && hit_ctrl && reg_ch == 2'(k)) begin
          ctl_q[k] <= i_pwdata[CTL_W-1:0];
        end
        if (apb_wr && hit_cnt && reg_ch == 2'(k)) begin
          cnt_q[k] <= i_pwdata[CNT_W-1:0];
        end else if (unit_end && cur_q == 2'(k)) begin
          cnt_q[k] <= CNT_W'(cnt_q[k] - CNT_W'(1));
        end
      end
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_bsc_req = bsc_req_q;
  assign o_bsc_chan = cur_q;
  assign o_bsc_write = (st_q == st_wr);
  assign o_bsc_single = ~c_dual;
  assign o_bus_hold = hold_q;
  assign o_transfer_ack_strobe = ack_q;
  assign o_request_accepted_pulse = acc_q;

  // Accepted pulse spans exactly one bus clock
  acc_width_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (bclk_en && acc_q[0]) |=> !acc_q[0])
    else $error("accepted pulse held past one bus clock");
  acc_cause_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(acc_q[1]) |-> $past(det[1]))
    else $error("accepted pulse without detection");
  no_resample_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q != st_idle && cur_oh[1] && ctl_q[1][F_BURST] && ctl_q[1][F_EDGE]
     && !c_last) |-> !det[1])
    else $error("edge burst sampled twice");
  early_start_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == st_idle && bclk_en && any_req && !hold_q) |=> st_q == st_wait)
    else $error("transfer skipped start latency");
  ack_single_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == st_rd && !c_dual) |=> ack_q[$past(cur_q)])
    else $error("no acknowledge in single cycle");
  ack_dual_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == st_wr && !cc[F_ACKWR]) |=> ack_q == '0)
    else $error("acknowledge in wrong dual cycle");
  steal_release_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (unit_end && !c_burst) |=> !hold_q)
    else $error("cycle steal kept the bus");
  hold_bsc_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    bsc_req_q |-> hold_q)
    else $error("bus cycle without bus held");
  chan_gate_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (!glb_q[G_HS] && det[2]) |-> 1'b0)
    else $error("channel 2 accepted outside handshake mode");
endmodule // dma_ext_req
`default_nettype wire

/* dma_ext_pkg.sv */
package dma_ext_pkg;
  localparam int NCH = 4;
  localparam int CNT_W = 24;
  localparam int AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CNT = 8'h10;
  localparam logic [7:0] OFS_GLB = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  // Channel control fields
  localparam int F_EN = 0;
  localparam int F_DUAL = 1;
  localparam int F_BURST = 2;
  localparam int F_EDGE = 3;
  localparam int F_ACKWR = 4;
  localparam int F_BLK = 5;
  localparam int F_MEM = 8;
  localparam int CTL_W = 11;
  // Global control fields
  localparam int G_HS = 0;
  localparam int G_RR = 1;
  // Earliest start in bus clocks after detection
  localparam logic [2:0] LAT_LEVEL = 3'h4;
  localparam logic [2:0] LAT_EDGE = 3'h5;
  localparam logic [2:0] LAT_BLK = 3'h6;
  typedef enum logic [2:0] {
    mem_sram, mem_bcsram, mem_brom, mem_dram, mem_sdram, mem_pcmcia, mem_mpx
  } mem_t;
  typedef enum logic [1:0] {st_idle, st_wait, st_rd, st_wr} seq_t;

  // Channel may take external requests in its configured form
  function automatic logic ext_ok(input logic [1:0] ch, input logic hs,
                                  input logic dual, input logic [2:0] mem);
    logic ch_ok;
    logic mem_ok;
    ch_ok = hs | (ch < 2'h2);
    if (dual) begin
      mem_ok = (mem != 3'(mem_dram)) && (mem <= 3'(mem_mpx));
    end else if (hs) begin
      mem_ok = (mem == 3'(mem_sdram));
    end else begin
      mem_ok = (mem <= 3'(mem_sdram));
    end
    return ch_ok & mem_ok;
  endfunction
endpackage

/* dma_req_sampler.sv */
`timescale 1ns/1ns
`default_nettype none
module dma_req_sampler
  import dma_ext_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_bclk_en,
  input wire logic i_req_n,
  output logic o_level,
  output logic o_edge
);
  logic sync1_q;
  logic sync2_q;
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Pin synchroniser, then bus-clock sample pipeline
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      sync1_q <= i_req_n;
      sync2_q <= sync1_q;
      if (i_bclk_en) begin
        s1_q <= sync2_q;
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end
  end

  // Low level seen after one bus clock, falling edge after two
  assign o_level = ~s1_q;
  assign o_edge = ~s2_q & s3_q;

  edge_delay_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_edge) |-> $past(~s1_q))
    else $error("edge seen without earlier low sample");
endmodule // dma_req_sampler
`default_nettype wire

/* dma_prio_arb.sv */
`timescale 1ns/1ns
`default_nettype none
module dma_prio_arb
  import dma_ext_pkg::*;
(
  input wire logic [NCH-1:0] i_req,
  input wire logic i_rr,
  input wire logic [1:0] i_last,
  output logic [1:0] o_idx,
  output logic o_any
);
  logic [1:0] start;
  logic [1:0] idx;

  // Fixed starts at channel 0, round robin after the last served
  assign start = i_rr ? 2'(i_last + 2'h1) : 2'h0;

  always_comb begin
    idx = 2'h0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (i_req[2'(start + 2'(k))]) begin
        idx = 2'(start + 2'(k));
      end
    end
  end

  assign o_idx = idx;
  assign o_any = |i_req;
endmodule // dma_prio_arb
`default_nettype wire

/* dma_ext_dev.sv */
`timescale 1ns/1ns
`default_nettype none
module dma_ext_dev (
  input wire logic i_external_bus_clock,
  input wire logic [3:0] i_want,
  input wire logic [3:0] i_once,
  input wire logic [3:0] i_request_accepted_pulse,
  output logic [3:0] o_ext_transfer_request_n
);
  logic [3:0] seen_q;
  wire [3:0] got = seen_q | i_request_accepted_pulse;
  initial begin
    o_ext_transfer_request_n = 4'hf;
    seen_q = 4'h0;
  end
  // Pins move only at rising bus clock edges; a one-shot device drops after acceptance
  always @(posedge i_external_bus_clock) begin
    seen_q <= i_want & got;
    o_ext_transfer_request_n <= ~(i_want & ~(i_once & got));
  end
endmodule // dma_ext_dev
`default_nettype wire

/* dma_ext_req_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module dma_ext_req_bench;
  import dma_ext_pkg::*;
  logic clk, rst_n, bclk, psel, pen, pwr, done, rdy, err, breq, bwr, bsgl, hold, ack_wr;
  logic [7:0] addr;
  logic [31:0] wd, rd;
  logic [1:0] bch, key;
  logic [3:0] req_n, ack, acc, accq, want, once;
  logic [2:0] sb;
  int n_mismatch, n_tests, nb, cnt;
  int pulses [4];

  dma_ext_req dma_ext_req_i (.i_clk(clk), .i_reset_n(rst_n), .i_external_bus_clock(bclk),
    .i_ext_transfer_request_n(req_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(addr), .i_pwdata(wd), .o_prdata(rd), .o_pready(rdy), .o_pslverr(err),
    .o_bsc_req(breq), .o_bsc_chan(bch), .o_bsc_write(bwr), .o_bsc_single(bsgl),
    .i_bsc_done(done), .o_bus_hold(hold), .o_transfer_ack_strobe(ack),
    .o_request_accepted_pulse(acc));
  dma_ext_dev dma_ext_dev_i (.i_external_bus_clock(bclk), .i_want(want), .i_once(once),
    .i_request_accepted_pulse(acc), .o_ext_transfer_request_n(req_n));

  // Clocks: 4 ns system clock, 125 ns bus clock
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial begin
    bclk = 0;
    #7;
    forever begin
      #62 bclk = 1;
      #63 bclk = 0;
    end
  end

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic stop;
    n_mismatch++;
    complete_run();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus edge count, accepted pulse count and bus state controller stand-in
  always @(posedge clk) begin
    sb <= {sb[1:0], bclk};
    accq <= acc;
    key <= {breq, bwr};
    if (sb[1] & ~sb[2]) nb <= nb + 1;
    for (int i = 0; i < 4; i++) if (acc[i] & ~accq[i]) pulses[i] <= pulses[i] + 1;
    cnt <= (key != {breq, bwr} || (sb[1] & ~sb[2])) ? 0 : cnt + 1;
    done <= breq && cnt == 2;
    if (rst_n && breq && cnt == 2) chk("ack", {31'h0, bsgl | (bwr == ack_wr)}, {31'h0, ack[bch]});
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (n >= 50) stop();
    q = rd;
    e = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask

  task automatic bw(input int k);
    repeat (k) @(posedge bclk);
    @(posedge clk);
  endtask

  // Bus clocks from acceptance to the first cycle request
  task automatic lat(input int ch, input int x);
    int t, b0;
    t = 0;
    while (acc[ch] !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    b0 = nb;
    while (breq !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 3000) stop();
    chk("latency", x, nb - b0);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd_chk("glb reset", OFS_GLB, 32'h0);
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    wr(OFS_CTRL, 32'h0000_0401);
    rd_chk("ctrl back", OFS_CTRL, 32'h0000_0401);
    $display("test regs done");
  endtask

  task automatic t_level;
    int p;
    p = pulses[0];
    ack_wr = 0;
    wr(OFS_CNT, 32'h2);
    want <= 4'h1;
    lat(0, 4);
    bw(30);
    want <= 4'h0;
    chk("level pulses", p + 2, pulses[0]);
    rd_chk("level count", OFS_CNT, 32'h0);
    chk("hold released", 32'h0, {31'h0, hold});
    $display("test level steal done");
  endtask

  task automatic t_edge_burst;
    int p;
    p = pulses[1];
    wr(OFS_CTRL + 8'h4, 32'h0000_040d);
    wr(OFS_CNT + 8'h4, 32'h3);
    want <= 4'h2;
    lat(1, 5);
    bw(3);
    chk("burst hold", 32'h1, {31'h0, hold});
    bw(30);
    want <= 4'h0;
    chk("burst pulses", p + 1, pulses[1]);
    rd_chk("burst count", OFS_CNT + 8'h4, 32'h0);
    $display("test edge burst done");
  endtask

  task automatic t_refuse;
    int p;
    p = pulses[2];
    wr(OFS_CTRL + 8'h8, 32'h0000_0401);
    wr(OFS_CNT + 8'h8, 32'h1);
    want <= 4'h4;
    bw(12);
    chk("ch2 normal", p, pulses[2]);
    wr(OFS_GLB, 32'h1);
    bw(20);
    want <= 4'h0;
    chk("ch2 handshake", p + 1, pulses[2]);
    rd_chk("ch2 count", OFS_CNT + 8'h8, 32'h0);
    wr(OFS_GLB, 32'h0);
    $display("test channel refusal done");
  endtask

  task automatic t_dual;
    int p;
    p = pulses[0];
    ack_wr = 1;
    wr(OFS_CTRL, 32'h0000_0013);
    wr(OFS_CNT, 32'h2);
    once <= 4'h1;
    want <= 4'h1;
    lat(0, 4);
    bw(25);
    want <= 4'h0;
    once <= 4'h0;
    chk("dual pulses", p + 1, pulses[0]);
    rd_chk("dual count", OFS_CNT, 32'h1);
    ack_wr = 0;
    wr(OFS_CTRL, 32'h0000_0003);
    want <= 4'h1;
    lat(0, 4);
    bw(12);
    want <= 4'h0;
    chk("read ack pulses", p + 2, pulses[0]);
    rd_chk("read ack count", OFS_CNT, 32'h0);
    $display("test dual ack done");
  endtask

  // Reset, scenarios and verdict
  initial begin
    rst_n = 0;
    psel = 0;
    pen = 0;
    pwr = 0;
    addr = 8'h0;
    wd = 32'h0;
    want = 4'h0;
    once = 4'h0;
    ack_wr = 0;
    sb = 3'h0;
    accq = 4'h0;
    key = 2'h0;
    done = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    t_regs();
    t_level();
    t_edge_burst();
    t_refuse();
    t_dual();
    complete_run();
  end
endmodule // dma_ext_req_bench
`default_nettype wire
